//--- rtl/pcm_pin_mux.sv
// Purpose: function multiplexer for the low five pins of the third port
// Assumes: pad inputs and alternate pin inputs are asynchronous and are synchronised here
// Notes:   all outputs are registered, so a control change reaches the pads one edge later
`default_nettype none
// How it works
// - output direction drives latch bit, ignoring analog
// - input direction reads pin unless analog
// - map fuses set pick default pins here
// - compare pin outputs or captures by direction
// - enhanced pwm outputs drive only when output
// - serial clock pin outputs or inputs by direction
// - serial data in by direction, two-wire outputs
// - pin zero and two feed timer inputs
// - charge pulse on pin two when digital output
module pcm_pin_mux
   import pcm_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       arst_n,
   // port controls
   input  wire logic [4:0] pin_direction_control,
   input  wire logic [2:0] analog_select,
   input  wire logic [4:0] output_latch,
   // configuration fuses
   input  wire logic       pwm_b_pin_map_fuse,
   input  wire logic       timer_clock_pin_map_fuse,
   input  wire logic       compare2_pin_map_fuse,
   input  wire logic       compare3_pin_map_fuse,
   // peripheral outputs and their enables
   input  wire logic       second_pwm_output_a,
   input  wire logic       second_pwm_a_en,
   input  wire logic       second_pwm_output_b,
   input  wire logic       second_pwm_b_en,
   input  wire logic       first_pwm_output_a,
   input  wire logic       first_pwm_a_en,
   input  wire logic       first_compare_out,
   input  wire logic       first_compare_out_en,
   input  wire logic       second_compare_out,
   input  wire logic       second_compare_out_en,
   input  wire logic       charge_time_pulse_out,
   input  wire logic       charge_time_pulse_en,
   input  wire logic       sync_serial_en,
   input  wire logic       serial_clock_out,
   input  wire logic       two_wire_mode,
   input  wire logic       two_wire_data_out,
   input  wire logic       secondary_osc_en,
   input  wire logic       secondary_osc_out,
   // alternate pin inputs used when a map fuse is clear
   input  wire logic       third_timer_clock_alt_pin,
   input  wire logic       second_capture_alt_pin,
   // pads
   input  wire logic [4:0] pad_in,
   output logic      [4:0] pad_out,
   output logic      [4:0] pad_oe,
   // alternate pin drive requests
   output logic            second_pwm_b_alt_out,
   output logic            second_pwm_b_alt_oe,
   output logic            second_compare_alt_out,
   output logic            second_compare_alt_oe,
   output logic            third_compare_on_default,
   // peripheral inputs
   output logic      [4:0] pin_input_value,
   output logic            first_timer_clock_in,
   output logic            third_timer_clock_in,
   output logic            third_timer_gate_in,
   output logic            fifth_timer_clock_in,
   output logic            first_capture_in,
   output logic            second_capture_in,
   output logic            serial_clock_in,
   output logic            serial_data_in,
   output logic            secondary_osc_in,
   output logic      [2:0] analog_connect
);

   logic [4:0] pad_s1_reg;
   logic [4:0] pad_s2_reg;
   logic [1:0] alt_s1_reg;
   logic [1:0] alt_s2_reg;
   logic [4:0] dir;
   logic [4:0] dig_in;
   logic [4:0] ana_full;
   logic [4:0] pad_out_next;
   logic [4:0] pad_oe_next;

   assign dir      = pin_direction_control;
   assign ana_full = {analog_select, 2'b00};

   // pad and alternate pin synchronisers
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pad_s1_reg <= PCM_PINS_RST;
         pad_s2_reg <= PCM_PINS_RST;
         alt_s1_reg <= 2'h0;
         alt_s2_reg <= 2'h0;
      end else begin
         pad_s1_reg <= pad_in;
         pad_s2_reg <= pad_s1_reg;
         alt_s1_reg <= {second_capture_alt_pin, third_timer_clock_alt_pin};
         alt_s2_reg <= alt_s1_reg;
      end
   end

   // digital input gated off by analog
   assign dig_in = pad_s2_reg & dir & ~ana_full;

   always_comb begin
      pad_out_next = output_latch;
      pad_oe_next  = ~dir;
      // pwm b on pin zero when mapped
      if (pwm_b_pin_map_fuse && second_pwm_b_en) begin
         pad_out_next[PCM_PIN_ZERO] = second_pwm_output_b;
      end
      if (second_pwm_a_en) begin
         pad_out_next[PCM_PIN_ONE] = second_pwm_output_a;
      end
      // compare two output on pin one
      if (compare2_pin_map_fuse && second_compare_out_en) begin
         pad_out_next[PCM_PIN_ONE] = second_compare_out;
      end
      if (first_compare_out_en) begin
         pad_out_next[PCM_PIN_TWO] = first_compare_out;
      end
      if (first_pwm_a_en) begin
         pad_out_next[PCM_PIN_TWO] = first_pwm_output_a;
      end
      if (charge_time_pulse_en && !ana_full[PCM_PIN_TWO]) begin
         pad_out_next[PCM_PIN_TWO] = charge_time_pulse_out;
      end
      if (sync_serial_en) begin
         pad_out_next[PCM_PIN_THREE] = serial_clock_out;
      end
      if (sync_serial_en && two_wire_mode) begin
         pad_out_next[PCM_PIN_FOUR] = two_wire_data_out;
      end
      // oscillator takes pins zero and one
      if (secondary_osc_en) begin
         pad_out_next[PCM_PIN_ZERO] = secondary_osc_out;
         pad_oe_next[PCM_PIN_ZERO]  = 1'b1;
         pad_out_next[PCM_PIN_ONE]  = 1'b0;
         pad_oe_next[PCM_PIN_ONE]   = 1'b0;
      end
   end

   // pad drive and alternate routing
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pad_out                  <= PCM_PINS_RST;
         pad_oe                   <= PCM_PINS_RST;
         second_pwm_b_alt_out     <= PCM_BIT_RST;
         second_pwm_b_alt_oe      <= PCM_BIT_RST;
         second_compare_alt_out   <= PCM_BIT_RST;
         second_compare_alt_oe    <= PCM_BIT_RST;
         third_compare_on_default <= PCM_BIT_RST;
      end else begin
         pad_out                  <= pad_out_next;
         pad_oe                   <= pad_oe_next;
         // fuse clear routes to alternate pins
         second_pwm_b_alt_out     <= second_pwm_output_b;
         second_pwm_b_alt_oe      <= !pwm_b_pin_map_fuse && second_pwm_b_en;
         second_compare_alt_out   <= second_compare_out;
         second_compare_alt_oe    <= !compare2_pin_map_fuse && second_compare_out_en;
         third_compare_on_default <= compare3_pin_map_fuse;
      end
   end

   // peripheral inputs
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pin_input_value      <= PCM_PINS_RST;
         first_timer_clock_in <= PCM_BIT_RST;
         third_timer_clock_in <= PCM_BIT_RST;
         third_timer_gate_in  <= PCM_BIT_RST;
         fifth_timer_clock_in <= PCM_BIT_RST;
         first_capture_in     <= PCM_BIT_RST;
         second_capture_in    <= PCM_BIT_RST;
         serial_clock_in      <= PCM_BIT_RST;
         serial_data_in       <= PCM_BIT_RST;
         secondary_osc_in     <= PCM_BIT_RST;
         analog_connect       <= PCM_ANA_RST;
      end else begin
         pin_input_value      <= dig_in;
         first_timer_clock_in <= dig_in[PCM_PIN_ZERO] && !secondary_osc_en;
         third_timer_gate_in  <= dig_in[PCM_PIN_ZERO] && !secondary_osc_en;
         third_timer_clock_in <= timer_clock_pin_map_fuse ?
                                 (dig_in[PCM_PIN_ZERO] && !secondary_osc_en) : alt_s2_reg[0];
         // fifth timer clock from pin two
         fifth_timer_clock_in <= dig_in[PCM_PIN_TWO];
         first_capture_in     <= dig_in[PCM_PIN_TWO];
         second_capture_in    <= compare2_pin_map_fuse ?
                                 (dig_in[PCM_PIN_ONE] && !secondary_osc_en) : alt_s2_reg[1];
         serial_clock_in      <= dig_in[PCM_PIN_THREE];
         serial_data_in       <= dig_in[PCM_PIN_FOUR];
         secondary_osc_in     <= secondary_osc_en && pad_s2_reg[PCM_PIN_ONE];
         analog_connect       <= analog_select & dir[PCM_PIN_FOUR:PCM_ANA_BASE];
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   sequence s_out_latch0;
      !dir[0] && !secondary_osc_en && !second_pwm_b_en;
   endsequence

   a_latch_drive_pin:   assert property (s_out_latch0 |=> pad_oe[0] && pad_out[0] == $past(output_latch[0]))
      else $error("pin zero not driven from latch");
   a_analog_blocks_in:  assert property (analog_select[2] |=> !pin_input_value[4])
      else $error("pin four digital input not disabled by analog");
   a_input_reads_pin:   assert property (dir[3] && !analog_select[1] |=> pin_input_value[3] == $past(pad_s2_reg[3]))
      else $error("pin three input wrong");
   a_pwmb_alt_map:      assert property (!pwm_b_pin_map_fuse && second_pwm_b_en |=> second_pwm_b_alt_oe)
      else $error("pwm b not routed to alternate pin");
   a_capture_by_dir:    assert property (!dir[2] |=> !first_capture_in)
      else $error("capture fed while pin two is output");
   a_pwm_only_output:   assert property (dir[1] && !secondary_osc_en |=> !pad_oe[1])
      else $error("pin one driven while input");
   a_serial_clock_out:  assert property (sync_serial_en && !dir[3] |=> pad_oe[3] && pad_out[3] == $past(serial_clock_out))
      else $error("serial clock output wrong");
   a_two_wire_data:     assert property (sync_serial_en && two_wire_mode && !dir[4]
                                         |=> pad_out[4] == $past(two_wire_data_out))
      else $error("two-wire data output wrong");
   a_timer_input_dir:   assert property (!dir[0] |=> !first_timer_clock_in && !third_timer_gate_in)
      else $error("timer input fed while pin zero is output");
   a_charge_pulse:      assert property (charge_time_pulse_en && !dir[2] && !analog_select[0]
                                         |=> pad_out[2] == $past(charge_time_pulse_out))
      else $error("charge pulse not on pin two");
   a_analog_connect:    assert property (analog_select[1] && dir[3] |=> analog_connect[1])
      else $error("channel fifteen not connected");
   a_osc_override:      assert property (secondary_osc_en |=> pad_oe[0] && !pad_oe[1])
      else $error("oscillator does not own pins");

endmodule : pcm_pin_mux
`default_nettype wire

//--- rtl/pcm_pkg.sv
// Purpose: shared constants for the low port pin function multiplexer
// Assumes: pins numbered zero to four, analog select exists on pins two to four
// Notes:   reset leaves every pin undriven and every peripheral input low
`default_nettype none
package pcm_pkg;
   localparam int unsigned PCM_NUM_PINS  = 5;
   localparam int unsigned PCM_NUM_ANA   = 3;
   localparam int unsigned PCM_SYNC_LEN  = 2;
   // pin positions
   localparam int unsigned PCM_PIN_ZERO  = 0;
   localparam int unsigned PCM_PIN_ONE   = 1;
   localparam int unsigned PCM_PIN_TWO   = 2;
   localparam int unsigned PCM_PIN_THREE = 3;
   localparam int unsigned PCM_PIN_FOUR  = 4;
   // analog select bit for pin two sits at index zero
   localparam int unsigned PCM_ANA_BASE  = 2;
   // values after reset
   localparam logic [4:0]  PCM_PINS_RST  = 5'h00;
   localparam logic [2:0]  PCM_ANA_RST   = 3'h0;
   localparam logic        PCM_BIT_RST   = 1'b0;
endpackage : pcm_pkg
`default_nettype wire

//--- testbench/pcm_board_model.sv
// Purpose: board circuitry on the five port pads
// Assumes: the board drives a pad only while ext_en is high for that pin
// Notes:   a pad nobody drives reads high through its pull-up
`default_nettype none
module pcm_board_model (
   // device side
   input  wire logic [4:0] pad_out,
   input  wire logic [4:0] pad_oe,
   // board side
   input  wire logic [4:0] ext_val,
   input  wire logic [4:0] ext_en,
   // resolved level
   output logic      [4:0] pad_in
);
   timeunit 1ns;
   timeprecision 1ps;
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         if (pad_oe[i]) begin
            pad_in[i] = pad_out[i];
         end else if (ext_en[i]) begin
            pad_in[i] = ext_val[i];
         end else begin
            pad_in[i] = 1'b1;
         end
      end
   end
endmodule : pcm_board_model
`default_nettype wire

//--- testbench/tb_top.sv
// Purpose: self-checking bench for the low port pin multiplexer
// Assumes: controls change at falling edges
// Notes:   each step waits four edges: one for drive, two for pad sync, one for the input register
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top
   import pcm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   int n_fail = 0;
   int compares = 0;
   logic clock = 1'b0, arst_n = 1'b0;
   logic [4:0] pin_direction_control = 5'h1F, output_latch = 5'h00, ext_val = 5'h00, ext_en = 5'h00, v;
   logic [2:0] analog_select = 3'h0;
   logic pwm_b_pin_map_fuse = 1'b1, timer_clock_pin_map_fuse = 1'b1, compare2_pin_map_fuse = 1'b1;
   logic compare3_pin_map_fuse = 1'b1, second_pwm_output_a = 1'b0, second_pwm_a_en = 1'b0;
   logic second_pwm_output_b = 1'b0, second_pwm_b_en = 1'b0, first_pwm_output_a = 1'b0, first_pwm_a_en = 1'b0;
   logic first_compare_out = 1'b0, first_compare_out_en = 1'b0, second_compare_out = 1'b0;
   logic second_compare_out_en = 1'b0, charge_time_pulse_out = 1'b0, charge_time_pulse_en = 1'b0;
   logic sync_serial_en = 1'b0, serial_clock_out = 1'b0, two_wire_mode = 1'b0, two_wire_data_out = 1'b0;
   logic secondary_osc_en = 1'b0, secondary_osc_out = 1'b0, third_timer_clock_alt_pin = 1'b0;
   logic second_capture_alt_pin = 1'b0;
   logic [4:0] pad_in, pad_out, pad_oe, pin_input_value;
   logic [2:0] analog_connect;
   logic second_pwm_b_alt_out, second_pwm_b_alt_oe, second_compare_alt_out, second_compare_alt_oe;
   logic third_compare_on_default, first_timer_clock_in, third_timer_clock_in, third_timer_gate_in;
   logic fifth_timer_clock_in, first_capture_in, second_capture_in, serial_clock_in, serial_data_in;
   logic secondary_osc_in;

   pcm_pin_mux pcm_pin_mux_i (
      .clock(clock), .arst_n(arst_n), .pin_direction_control(pin_direction_control),
      .analog_select(analog_select), .output_latch(output_latch), .pwm_b_pin_map_fuse(pwm_b_pin_map_fuse),
      .timer_clock_pin_map_fuse(timer_clock_pin_map_fuse), .compare2_pin_map_fuse(compare2_pin_map_fuse),
      .compare3_pin_map_fuse(compare3_pin_map_fuse), .second_pwm_output_a(second_pwm_output_a),
      .second_pwm_a_en(second_pwm_a_en), .second_pwm_output_b(second_pwm_output_b),
      .second_pwm_b_en(second_pwm_b_en), .first_pwm_output_a(first_pwm_output_a), .first_pwm_a_en(first_pwm_a_en),
      .first_compare_out(first_compare_out), .first_compare_out_en(first_compare_out_en),
      .second_compare_out(second_compare_out), .second_compare_out_en(second_compare_out_en),
      .charge_time_pulse_out(charge_time_pulse_out), .charge_time_pulse_en(charge_time_pulse_en),
      .sync_serial_en(sync_serial_en), .serial_clock_out(serial_clock_out), .two_wire_mode(two_wire_mode),
      .two_wire_data_out(two_wire_data_out), .secondary_osc_en(secondary_osc_en),
      .secondary_osc_out(secondary_osc_out), .third_timer_clock_alt_pin(third_timer_clock_alt_pin),
      .second_capture_alt_pin(second_capture_alt_pin), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
      .second_pwm_b_alt_out(second_pwm_b_alt_out), .second_pwm_b_alt_oe(second_pwm_b_alt_oe),
      .second_compare_alt_out(second_compare_alt_out), .second_compare_alt_oe(second_compare_alt_oe),
      .third_compare_on_default(third_compare_on_default), .pin_input_value(pin_input_value),
      .first_timer_clock_in(first_timer_clock_in), .third_timer_clock_in(third_timer_clock_in),
      .third_timer_gate_in(third_timer_gate_in), .fifth_timer_clock_in(fifth_timer_clock_in),
      .first_capture_in(first_capture_in), .second_capture_in(second_capture_in),
      .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in), .secondary_osc_in(secondary_osc_in),
      .analog_connect(analog_connect)
   );
   pcm_board_model pcm_board_model_i (
      .pad_out(pad_out), .pad_oe(pad_oe), .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in)
   );

   always #5 clock = ~clock;

   task automatic settle();
      repeat (4) @(posedge clock);
      @(negedge clock);
   endtask : settle

   task automatic end_sim();
      $display("n_fail=%0d compares=%0d", n_fail, compares);
      if (n_fail == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim

   // watchdog against a hung run
   initial begin
      repeat (3000) @(posedge clock);
      n_fail++;
      end_sim();
   end

   initial begin
      repeat (10) @(posedge clock);
      `CHK(pad_oe, PCM_PINS_RST)
      `CHK(pin_input_value, PCM_PINS_RST)
      @(negedge clock);
      arst_n = 1'b1;
      pin_direction_control = 5'h00;
      output_latch = 5'h15;
      analog_select = 3'h7;
      settle();
      `CHK(pad_oe, 5'h1F)
      `CHK(pad_out, 5'h15)
      `CHK(pin_input_value, 5'h00)
      pin_direction_control = 5'h0B;
      ext_en = 5'h1F;
      ext_val = 5'h1B;
      settle();
      `CHK(pad_oe, 5'h14)
      `CHK(pin_input_value, 5'h03)
      `CHK(analog_connect, 3'h2)
      pin_direction_control = 5'h1F;
      analog_select = 3'h0;
      for (int k = 0; k < 2; k++) begin
         v = k ? 5'h02 : 5'h1D;
         ext_val = v;
         settle();
         `CHK(pin_input_value, v)
         `CHK(first_timer_clock_in, v[0])
         `CHK(third_timer_gate_in, v[0])
         `CHK(third_timer_clock_in, v[0])
         `CHK(fifth_timer_clock_in, v[2])
         `CHK(first_capture_in, v[2])
         `CHK(second_capture_in, v[1])
         `CHK(serial_clock_in, v[3])
         `CHK(serial_data_in, v[4])
      end
      pin_direction_control = 5'h00;
      output_latch = 5'h00;
      {pwm_b_pin_map_fuse, timer_clock_pin_map_fuse, compare2_pin_map_fuse, compare3_pin_map_fuse} = 4'h0;
      {second_pwm_b_en, second_pwm_output_b, second_compare_out_en, second_compare_out} = 4'hF;
      {third_timer_clock_alt_pin, second_capture_alt_pin} = 2'h3;
      settle();
      `CHK(pad_out, 5'h00)
      `CHK({second_pwm_b_alt_oe, second_pwm_b_alt_out, second_compare_alt_oe, second_compare_alt_out}, 4'hF)
      `CHK({third_compare_on_default, third_timer_clock_in, second_capture_in}, 3'h3)
      {pwm_b_pin_map_fuse, timer_clock_pin_map_fuse, compare2_pin_map_fuse, compare3_pin_map_fuse} = 4'hF;
      {second_compare_out, second_pwm_a_en, second_pwm_output_a, first_pwm_a_en, first_pwm_output_a} = 5'h0F;
      settle();
      `CHK(pad_out, 5'h05)
      `CHK({second_pwm_b_alt_oe, second_compare_alt_oe, third_compare_on_default}, 3'h1)
      pin_direction_control = 5'h1F;
      settle();
      `CHK(pad_oe, 5'h00)
      pin_direction_control = 5'h00;
      {second_pwm_b_en, second_compare_out_en, second_pwm_a_en, first_pwm_a_en} = 4'h0;
      {first_compare_out_en, first_compare_out, sync_serial_en, serial_clock_out, two_wire_mode} = 5'h1F;
      output_latch = 5'h10;
      settle();
      `CHK(pad_out, 5'h0C)
      // compare drives one, so a low pin proves the pulse won
      {charge_time_pulse_en, charge_time_pulse_out, first_compare_out} = 3'h5;
      settle();
      `CHK(pad_out[2], 1'b0)
      // analog on pin two keeps the pulse off the pin
      analog_select = 3'h1;
      settle();
      `CHK(pad_out[2], 1'b1)
      pin_direction_control = 5'h1F;
      {secondary_osc_en, secondary_osc_out} = 2'h3;
      ext_en = 5'h02;
      ext_val = 5'h02;
      settle();
      `CHK(pad_oe[1:0], 2'h1)
      `CHK({pad_out[0], secondary_osc_in, first_timer_clock_in}, 3'h6)
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
